// *** inc/sfbr_defines.svh ***
`ifndef SFBR_DEFINES_SVH
`define SFBR_DEFINES_SVH
// ----------------------------------------------------------------------
// Flash opcodes and frame layout
// ----------------------------------------------------------------------
`define SFBR_OP_FAST_READ 8'h0B
`define SFBR_OP_WR_ENABLE 8'h06
`define SFBR_OP_PAGE_PROG 8'h02
`define SFBR_ADDR_BYTES   3
`define SFBR_DUMMY_BYTES  1
// ----------------------------------------------------------------------
// Boot header: location, size, field positions
// ----------------------------------------------------------------------
`define SFBR_HDR_ADDR     24'h000000
`define SFBR_HDR_LEN      24'h000008
`define SFBR_HDR_LEN_LSB  0
`define SFBR_HDR_ADR_LSB  32
// ----------------------------------------------------------------------
// Link timing and buffering
// ----------------------------------------------------------------------
`define SFBR_LINK_PERIOD_PS 6000
`define SFBR_CS_HIGH_NS     300
`define SFBR_CS_HIGH_CYC \
  ((`SFBR_CS_HIGH_NS * 1000 + `SFBR_LINK_PERIOD_PS - 1) / `SFBR_LINK_PERIOD_PS)
`define SFBR_FIFO_WIDTH   8
`define SFBR_FIFO_DEPTH   8
`endif

// *** inc/sfbr_pkg.sv ***
`default_nettype none

package sfbr_pkg;
  typedef enum logic [1:0] {
    OP_READ = 2'h0,
    OP_WREN = 2'h1,
    OP_PROG = 2'h2
  } sfbr_op_type;

  typedef enum logic [3:0] {
    L_IDLE  = 4'h1,
    L_SHIFT = 4'h2,
    L_WAIT  = 4'h4,
    L_GAP   = 4'h8
  } sfbr_lst_type;

  typedef enum logic [6:0] {
    C_OFF   = 7'h01,
    C_HDR   = 7'h02,
    C_LOAD  = 7'h04,
    C_DRAIN = 7'h08,
    C_RUN   = 7'h10,
    C_WREN  = 7'h20,
    C_PROG  = 7'h40
  } sfbr_cst_type;

  typedef struct packed {
    sfbr_lst_type st;
    logic [1:0]   ph;
    logic [2:0]   bitCnt;
    logic [2:0]   txLeft;
    logic [23:0]  rxLeft;
    logic [39:0]  sr;
    logic [7:0]   rx;
    logic [7:0]   rxByte;
    logic         rxTgl;
    logic         ack;
    logic         sck;
    logic         csN;
    logic         drive;
    logic [5:0]   gap;
    logic         reqS1;
    logic         reqS2;
    logic         ackS1;
    logic         ackS2;
    logic         misoS1;
    logic         misoS2;
  } sfbr_link_type;

  typedef struct packed {
    sfbr_cst_type st;
    logic         cmdReq;
    sfbr_op_type  cmdOp;
    logic [23:0]  cmdAddr;
    logic [23:0]  cmdLen;
    logic [7:0]   cmdData;
    logic [63:0]  hdr;
    logic         ackS1;
    logic         ackS2;
    logic         tglS1;
    logic         tglS2;
    logic         byteAckTgl;
    logic         pwrS1;
    logic         pwrS2;
    logic         initDone;
    logic         pwrEn;
  } sfbr_core_type;
endpackage : sfbr_pkg

`default_nettype wire

// *** hdl/sfbr_fifo.sv ***
`timescale 1ns/10ps
`default_nettype none

module sfbr_fifo
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
)
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
  } sfbr_fifo_type;

  sfbr_fifo_type q;
  sfbr_fifo_type d;
  logic          push;
  logic          pop;

  // Depth need not be a power of two, so pointers wrap explicitly
  function automatic logic [AW-1:0] nextPtr(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : nextPtr

  always_comb
  begin
    d        = q;
    inReady  = (q.cnt != (AW+1)'(DEPTH));
    outValid = (q.cnt != '0);
    outData  = q.mem[q.rp];
    push     = inValid && inReady;
    pop      = outValid && outReady;
    if (push)
    begin
      d.mem[q.wp] = inData;
      d.wp        = nextPtr(q.wp);
    end
    if (pop)
      d.rp = nextPtr(q.rp);
    if (push && !pop)
      d.cnt = q.cnt + (AW+1)'(1);
    else if (pop && !push)
      d.cnt = q.cnt - (AW+1)'(1);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      q <= '0;
    else
      q <= d;
  end
endmodule : sfbr_fifo

`default_nettype wire

// *** hdl/sfbr_boot_reader.sv ***
// How it works
// (RQ1) Reads use fast read, three address, one dummy
// (RQ2) Flash must take fixed clock above 33.3MHz
// (RQ3) Reads ignore flash page and sector sizes
// (RQ4) Flash writes go out as page programming
// (RQ5) Board plans user data around sector size
// (RQ6) Pause and write-protect inputs never driven
// (RQ7) Clock, data, primary select float in reset
// (RQ8) Secondary select stays driven during reset
// (RQ9) Programmer drives flash only while we float
// (RQ10) Power request high starts boot and display
// (RQ11) Power request low powers system down
// (RQ12) Mode 0: idle low, sample rising edge
// (RQ13) Boot header bytes 0-7 read first, primary
// (RQ14) Init complete pin set after routine loads
// (RQ15) Flash auto-increments address during one read
// (RQ16) Select low for whole command, high between
`timescale 1ns/10ps
`default_nettype none
`include "sfbr_defines.svh"

module sfbr_boot_reader
(
  // Clocks and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        linkClk,
  // Flash pins
  output logic             flashSerialClock,
  output logic             flashSerialClockOeN,
  output logic             flashSerialOut,
  output logic             flashSerialOutOeN,
  output logic             flashSelectPrimary,
  output logic             flashSelectPrimaryOeN,
  output logic             flashSelectSecondary,
  input  wire logic        flashSerialIn,
  // System control
  input  wire logic        projectorPowerRequest,
  output logic             initCompletePin,
  output logic             systemPowerEn,
  // Program memory stream
  output logic             progValid,
  input  wire logic        progReady,
  output logic [7:0]       progData,
  // Flash write requests
  input  wire logic        pgmValid,
  output logic             pgmReady,
  input  wire logic [23:0] pgmAddr,
  input  wire logic [7:0]  pgmData
);
  sfbr_pkg::sfbr_link_type lq;
  sfbr_pkg::sfbr_link_type ln;
  sfbr_pkg::sfbr_core_type cq;
  sfbr_pkg::sfbr_core_type cn;
  logic                    fifoInValid;
  logic                    fifoInReady;
  logic                    cmdIdle;
  logic                    bytePend;

  localparam logic [5:0] CS_GAP = 6'(`SFBR_CS_HIGH_CYC);

  function automatic logic [2:0] txBytes(input sfbr_pkg::sfbr_op_type op);
    return (op == sfbr_pkg::OP_WREN) ? 3'h1 :
           3'(1 + `SFBR_ADDR_BYTES + `SFBR_DUMMY_BYTES);
  endfunction : txBytes

  // ----------------------------------------------------------------------
  // Link side: serial engine on the link clock
  // ----------------------------------------------------------------------
  // Serial clock is the link clock over four, one rate for all commands
  always_comb
  begin
    ln        = lq;
    ln.reqS1  = cq.cmdReq;
    ln.reqS2  = lq.reqS1;
    ln.ackS1  = cq.byteAckTgl;
    ln.ackS2  = lq.ackS1;
    ln.misoS1 = flashSerialIn;
    ln.misoS2 = lq.misoS1;
    ln.drive  = 1'b1; // RQ7
    unique case (lq.st)
      sfbr_pkg::L_IDLE:
      begin
        ln.sck = 1'b0;
        if (!lq.reqS2)
          ln.ack = 1'b0;
        else if (!lq.ack)
        begin
          ln.st     = sfbr_pkg::L_SHIFT;
          ln.csN    = 1'b0; // RQ16
          ln.ph     = 2'h0;
          ln.bitCnt = 3'h0;
          ln.gap    = 6'h00;
          ln.txLeft = txBytes(cq.cmdOp); // RQ1
          ln.rxLeft = (cq.cmdOp == sfbr_pkg::OP_READ) ? cq.cmdLen : 24'h0;
          unique case (cq.cmdOp)
            sfbr_pkg::OP_READ:
              ln.sr = {`SFBR_OP_FAST_READ, cq.cmdAddr, 8'h00}; // RQ1
            sfbr_pkg::OP_WREN:
              ln.sr = {`SFBR_OP_WR_ENABLE, 32'h00000000}; // RQ4
            default:
              ln.sr = {`SFBR_OP_PAGE_PROG, cq.cmdAddr, cq.cmdData}; // RQ4
          endcase
        end
      end
      sfbr_pkg::L_SHIFT:
      begin
        ln.ph  = lq.ph + 2'h1;
        // High for phases 2 and 3; data moves only as the clock falls
        ln.sck = (lq.ph == 2'h1) || (lq.ph == 2'h2); // RQ12
        if (lq.ph == 2'h3)
        begin
          ln.bitCnt = lq.bitCnt + 3'h1;
          if (lq.txLeft != 3'h0)
            ln.sr = {lq.sr[38:0], 1'b0};
          else
            ln.rx = {lq.rx[6:0], lq.misoS2}; // RQ12
          if (lq.bitCnt == 3'h7)
          begin
            if (lq.txLeft != 3'h0)
            begin
              ln.txLeft = lq.txLeft - 3'h1;
              if (lq.txLeft == 3'h1 && lq.rxLeft == 24'h0)
                ln.st = sfbr_pkg::L_GAP;
            end
            else
            begin
              ln.rxByte = {lq.rx[6:0], lq.misoS2};
              ln.rxTgl  = ~lq.rxTgl;
              // One command streams on; page edges mean nothing here
              ln.rxLeft = lq.rxLeft - 24'h1; // RQ3 RQ15
              ln.st     = sfbr_pkg::L_WAIT;
            end
          end
        end
      end
      sfbr_pkg::L_WAIT:
      begin
        // Clock parks low with select still low until the byte is taken
        ln.sck = 1'b0;
        if (lq.ackS2 == lq.rxTgl)
          ln.st = (lq.rxLeft == 24'h0) ? sfbr_pkg::L_GAP
                                       : sfbr_pkg::L_SHIFT; // RQ16
      end
      sfbr_pkg::L_GAP:
      begin
        ln.sck = 1'b0;
        ln.csN = 1'b1; // RQ16
        if (lq.gap == CS_GAP)
        begin
          ln.st  = sfbr_pkg::L_IDLE;
          ln.ack = 1'b1;
        end
        else
          ln.gap = lq.gap + 6'h01;
      end
    endcase
  end

  // Release is not synchronised: the engine idles until a request arrives
  always_ff @(posedge linkClk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lq     <= '0;
      lq.st  <= sfbr_pkg::L_IDLE;
      lq.csN <= 1'b1;
      lq.gap <= CS_GAP;
    end
    else
      lq <= ln;
  end

  // ----------------------------------------------------------------------
  // Flash pins
  // ----------------------------------------------------------------------
  // Enables stay high in reset so a programmer may take the pins
  assign flashSerialClock      = lq.sck;
  assign flashSerialOut        = lq.sr[39];
  assign flashSelectPrimary    = lq.csN;
  assign flashSerialClockOeN   = ~lq.drive; // RQ7 RQ9
  assign flashSerialOutOeN     = ~lq.drive; // RQ7 RQ9
  assign flashSelectPrimaryOeN = ~lq.drive; // RQ7 RQ9
  // Not released by reset; pause and write-protect have no pins here
  assign flashSelectSecondary  = 1'b1; // RQ8 RQ6

  // ----------------------------------------------------------------------
  // Core side: boot sequence on the reference clock
  // ----------------------------------------------------------------------
  always_comb
  begin
    cn          = cq;
    cn.ackS1    = lq.ack;
    cn.ackS2    = cq.ackS1;
    cn.tglS1    = lq.rxTgl;
    cn.tglS2    = cq.tglS1;
    cn.pwrS1    = projectorPowerRequest;
    cn.pwrS2    = cq.pwrS1;
    fifoInValid = 1'b0;
    cmdIdle     = !cq.cmdReq && !cq.ackS2;
    bytePend    = cq.tglS2 != cq.byteAckTgl;
    if (cq.cmdReq && cq.ackS2)
      cn.cmdReq = 1'b0;
    // Bytes outside a load are still taken so the engine never hangs
    if (bytePend)
    begin
      if (cq.st == sfbr_pkg::C_LOAD)
      begin
        fifoInValid = 1'b1;
        if (fifoInReady)
          cn.byteAckTgl = ~cq.byteAckTgl;
      end
      else
      begin
        if (cq.st == sfbr_pkg::C_HDR)
          cn.hdr = {lq.rxByte, cq.hdr[63:8]};
        cn.byteAckTgl = ~cq.byteAckTgl;
      end
    end
    unique case (cq.st)
      sfbr_pkg::C_OFF:
        if (cq.pwrS2 && cmdIdle)
        begin
          cn.st      = sfbr_pkg::C_HDR; // RQ10
          cn.cmdReq  = 1'b1;
          cn.cmdOp   = sfbr_pkg::OP_READ;
          cn.cmdAddr = `SFBR_HDR_ADDR; // RQ13
          cn.cmdLen  = `SFBR_HDR_LEN; // RQ13
        end
      sfbr_pkg::C_HDR:
        if (cmdIdle)
        begin
          cn.cmdAddr = cq.hdr[`SFBR_HDR_ADR_LSB +: 24];
          cn.cmdLen  = cq.hdr[`SFBR_HDR_LEN_LSB +: 24];
          if (cq.hdr[`SFBR_HDR_LEN_LSB +: 24] == 24'h0)
            cn.st = sfbr_pkg::C_DRAIN;
          else
          begin
            cn.st     = sfbr_pkg::C_LOAD; // RQ13
            cn.cmdReq = 1'b1;
          end
        end
      sfbr_pkg::C_LOAD:
        if (cmdIdle)
          cn.st = sfbr_pkg::C_DRAIN;
      sfbr_pkg::C_DRAIN:
        if (!progValid)
        begin
          cn.st       = sfbr_pkg::C_RUN;
          cn.initDone = 1'b1; // RQ14
        end
      sfbr_pkg::C_RUN:
        if (pgmValid)
        begin
          cn.st      = sfbr_pkg::C_WREN;
          cn.cmdReq  = 1'b1;
          cn.cmdOp   = sfbr_pkg::OP_WREN; // RQ4
          cn.cmdAddr = pgmAddr;
          cn.cmdData = pgmData;
        end
      sfbr_pkg::C_WREN:
        if (cmdIdle)
        begin
          cn.st     = sfbr_pkg::C_PROG;
          cn.cmdReq = 1'b1;
          cn.cmdOp  = sfbr_pkg::OP_PROG; // RQ4
        end
      sfbr_pkg::C_PROG:
        if (cmdIdle)
          cn.st = sfbr_pkg::C_RUN;
      default:
        cn.st = sfbr_pkg::C_OFF;
    endcase
    // Power-down wins over the next state at once; a command issued in that cycle or already running still ends on the link
    if (!cq.pwrS2)
    begin
      cn.st       = sfbr_pkg::C_OFF; // RQ11
      cn.initDone = 1'b0; // RQ11
    end
    cn.pwrEn = (cn.st != sfbr_pkg::C_OFF); // RQ10 RQ11
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cq    <= '0;
      cq.st <= sfbr_pkg::C_OFF;
    end
    else
      cq <= cn;
  end

  assign initCompletePin = cq.initDone;
  assign systemPowerEn   = cq.pwrEn;
  assign pgmReady        = (cq.st == sfbr_pkg::C_RUN);

  // ----------------------------------------------------------------------
  // Routine buffer toward program memory
  // ----------------------------------------------------------------------
  sfbr_fifo #(
    .WIDTH (`SFBR_FIFO_WIDTH),
    .DEPTH (`SFBR_FIFO_DEPTH)
  ) uFifo (
    .clk      (ref_clk),
    .rst_n    (rst_n),
    .inValid  (fifoInValid),
    .inReady  (fifoInReady),
    .inData   (lq.rxByte),
    .outValid (progValid),
    .outReady (progReady),
    .outData  (progData)
  );

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence sCmdIdle;
    !cq.cmdReq && !cq.ackS2;
  endsequence

  sequence sDrained;
    cq.st == sfbr_pkg::C_DRAIN && !progValid && cq.pwrS2;
  endsequence

  AST_OPCODE: assert property ( // RQ1
    @(posedge linkClk) disable iff (!rst_n)
    lq.st == sfbr_pkg::L_SHIFT && $past(lq.st) == sfbr_pkg::L_IDLE &&
    cq.cmdOp == sfbr_pkg::OP_READ
    |-> lq.sr[39:32] == `SFBR_OP_FAST_READ && lq.txLeft == 3'h5)
    else $error("fast read frame wrong");

  AST_CS_LOW: assert property ( // RQ16
    @(posedge linkClk) disable iff (!rst_n)
    lq.st == sfbr_pkg::L_SHIFT || lq.st == sfbr_pkg::L_WAIT
    |-> !lq.csN)
    else $error("select high inside a command");

  AST_CS_GAP: assert property ( // RQ16
    @(posedge linkClk) disable iff (!rst_n)
    $fell(lq.csN) |-> $past(lq.gap) == CS_GAP)
    else $error("select high time too short");

  AST_MODE0: assert property ( // RQ12
    @(posedge linkClk) disable iff (!rst_n)
    $rose(lq.sck) |-> !lq.csN ##1 lq.sck ##1 !lq.sck)
    else $error("serial clock shape wrong");

  // Checked inside reset itself, so it must not be disabled by it
  AST_RELEASE: assert property ( // RQ7
    @(posedge linkClk)
    !rst_n ##1 !rst_n |-> flashSerialClockOeN && flashSerialOutOeN &&
                          flashSelectPrimaryOeN && flashSelectPrimary)
    else $error("pins not released");

  AST_HDR_FIRST: assert property ( // RQ13
    @(posedge ref_clk) disable iff (!rst_n)
    $rose(cq.st == sfbr_pkg::C_HDR)
    |-> cq.cmdReq && cq.cmdAddr == `SFBR_HDR_ADDR &&
        cq.cmdLen == `SFBR_HDR_LEN)
    else $error("header fetch not first");

  AST_INIT_DONE: assert property ( // RQ14
    @(posedge ref_clk) disable iff (!rst_n)
    sDrained |=> cq.initDone && initCompletePin)
    else $error("init complete missing");

  AST_PWR_OFF: assert property ( // RQ11
    @(posedge ref_clk) disable iff (!rst_n)
    !cq.pwrS2 |=> cq.st == sfbr_pkg::C_OFF && !systemPowerEn &&
                  !initCompletePin)
    else $error("power down ignored");

  AST_PWR_ON: assert property ( // RQ10
    @(posedge ref_clk) disable iff (!rst_n)
    cq.st == sfbr_pkg::C_OFF && cq.pwrS2 ##0 sCmdIdle
    |=> cq.st == sfbr_pkg::C_HDR && systemPowerEn)
    else $error("power up ignored");

  AST_PROG: assert property ( // RQ4
    @(posedge ref_clk) disable iff (!rst_n)
    $rose(cq.st == sfbr_pkg::C_PROG)
    |-> $past(cq.st) == sfbr_pkg::C_WREN && cq.cmdOp == sfbr_pkg::OP_PROG)
    else $error("page program without write enable");
endmodule : sfbr_boot_reader

`default_nettype wire

// *** tb/sfbr_flash_model.sv ***
`timescale 1ns/10ps
`default_nettype none

module sfbr_flash_model
(
  // Serial pins
  input  wire logic        sck,
  input  wire logic        csN,
  input  wire logic        mosi,
  output logic             miso,
  // Observation
  output logic [7:0]       lastOp,
  output logic [23:0]      lastAddr,
  output int               frames,
  output int               errs
);
  // ----------------------------------------------------------------
  // Storage: boot header at 0, routine at 0x10
  // ----------------------------------------------------------------
  logic [7:0]  mem [0:255];
  logic [7:0]  sh;
  logic [7:0]  cmd;
  logic [23:0] adr;
  logic        wel;
  int          nBits;
  realtime     tHigh;

  initial
  begin
    foreach (mem[i]) mem[i] = (i < 8) ? 8'h00 : 8'(8'hA0 + i);
    mem[4] = 8'h10;
    miso = 1'b0;
    frames = 0;
    errs = 0;
    nBits = 0;
    wel = 1'b0;
    cmd = 8'h00;
    tHigh = -1000.0;
  end

  // ----------------------------------------------------------------
  // Framing
  // ----------------------------------------------------------------
  // Clock must idle low at select; short deselect gaps are counted
  always @(negedge csN)
  begin
    if (sck !== 1'b0 || $realtime - tHigh < 300.0) errs++;
    nBits = 0;
  end

  // Released line shows the inverse, never a stale value
  always @(posedge csN)
  begin
    tHigh = $realtime;
    if (nBits % 8 != 0) errs++;
    if (nBits > 0) frames++;
    miso = ~miso;
  end

  // Sample on the rising edge
  always @(posedge sck)
  begin
    if (csN === 1'b0)
    begin
      sh = {sh[6:0], mosi};
      nBits++;
      if (nBits == 8)
      begin
        cmd = sh;
        lastOp = sh;
        if (sh == 8'h06) wel = 1'b1;
      end
      else if (nBits % 8 == 0 && nBits <= 32)
      begin
        adr = {adr[15:0], sh};
        if (nBits == 32) lastAddr = adr;
      end
      else if (nBits == 40 && cmd == 8'h02 && wel)
      begin
        mem[adr[7:0]] = sh;
        wel = 1'b0;
      end
    end
  end

  // Data changes on the falling edge; any clock rate accepted
  always @(negedge sck)
  begin
    if (csN === 1'b0 && cmd == 8'h0B && nBits >= 40)
      miso = mem[8'(adr + (nBits - 40) / 8)][7 - nBits % 8];
  end
endmodule : sfbr_flash_model

`default_nettype wire

// *** tb/spi_flash_boot_reader_tb.sv ***
`timescale 1ns/10ps
`default_nettype none

module spi_flash_boot_reader_tb;
  logic        ref_clk;
  logic        rst_n;
  logic        linkClk;
  logic        dutSck, sckOeN, dutDout, doutOeN, dutCs, csOeN;
  logic        flashSelectSecondary;
  logic        projectorPowerRequest;
  logic        initCompletePin, systemPowerEn;
  logic        progValid, progReady;
  logic [7:0]  progData;
  logic        pgmValid, pgmReady;
  logic [23:0] pgmAddr;
  logic [7:0]  pgmData;
  logic        extOn, extSck, extCs, extMosi;
  logic        misoW;
  logic [7:0]  lastOp;
  logic [23:0] lastAddr;
  int          frames, errs;
  int          nMismatch = 0;
  int          checked = 0;
  // Clock pulled low, select pulled high when nobody drives
  wire         sckW  = !sckOeN ? dutSck : extOn ? extSck : 1'b0;
  wire         csW   = !csOeN ? dutCs : extOn ? extCs : 1'b1;
  wire         mosiW = !doutOeN ? dutDout : extOn ? extMosi : ~dutDout;

  sfbr_boot_reader u_dut
  (
    .ref_clk(ref_clk), .rst_n(rst_n), .linkClk(linkClk),
    .flashSerialClock(dutSck), .flashSerialClockOeN(sckOeN),
    .flashSerialOut(dutDout), .flashSerialOutOeN(doutOeN),
    .flashSelectPrimary(dutCs), .flashSelectPrimaryOeN(csOeN),
    .flashSelectSecondary(flashSelectSecondary), .flashSerialIn(misoW),
    .projectorPowerRequest(projectorPowerRequest),
    .initCompletePin(initCompletePin), .systemPowerEn(systemPowerEn),
    .progValid(progValid), .progReady(progReady), .progData(progData),
    .pgmValid(pgmValid), .pgmReady(pgmReady), .pgmAddr(pgmAddr),
    .pgmData(pgmData)
  );

  sfbr_flash_model u_flash
  (
    .sck(sckW), .csN(csW), .mosi(mosiW), .miso(misoW),
    .lastOp(lastOp), .lastAddr(lastAddr), .frames(frames), .errs(errs)
  );

  // ----------------------------------------------------------------
  // Clocks, unrelated in phase
  // ----------------------------------------------------------------
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  initial
  begin
    linkClk = 1'b0;
    #1.7;
    forever #3 linkClk = ~linkClk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      nMismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic results;
    $display("checked %0d, mismatches %0d", checked, nMismatch);
    if (nMismatch == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results

  // Programmer select edge, then a gap well above the deselect minimum
  task automatic ext_cs(input logic v);
    @(posedge ref_clk);
    #2 extCs = v;
    repeat (9) @(posedge ref_clk);
  endtask : ext_cs

  // Mode 0 byte from the external programmer, MSB first
  task automatic ext_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      @(posedge ref_clk);
      #2 extSck = 1'b0;
      extMosi = b[i];
      @(posedge ref_clk);
      #2 extSck = 1'b1;
    end
    @(posedge ref_clk);
    #2 extSck = 1'b0;
  endtask : ext_byte

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Reset floats the pins; the programmer patches the length byte
  task automatic t_programmer;
    int f0;
    @(posedge ref_clk);
    #2 rst_n = 1'b0;
    repeat (3) @(posedge ref_clk);
    chk({sckOeN, doutOeN, csOeN}, 3'b111);
    chk(flashSelectSecondary, 1'b1);
    chk({initCompletePin, systemPowerEn, progValid, pgmReady}, 4'h0);
    f0 = frames;
    extOn = 1'b1;
    ext_cs(1'b0);
    ext_byte(8'h06);
    ext_cs(1'b1);
    ext_cs(1'b0);
    ext_byte(8'h02);
    repeat (3) ext_byte(8'h00);
    ext_byte(8'h0C);
    ext_cs(1'b1);
    extOn = 1'b0;
    chk(32'(frames - f0), 2);
    chk(u_flash.mem[0], 8'h0C);
    #2 rst_n = 1'b1;
  endtask : t_programmer

  // Boot with the sink stalled until the buffer fills, then drained
  task automatic t_boot;
    int f0;
    int k;
    f0 = frames;
    @(posedge ref_clk);
    #2 projectorPowerRequest = 1'b1;
    for (int i = 0; i < 10 && systemPowerEn !== 1'b1; i++) @(negedge ref_clk);
    chk(systemPowerEn, 1'b1);
    repeat (600) @(negedge ref_clk);
    chk(progValid, 1'b1);
    chk(csW, 1'b0);
    chk(32'(frames - f0), 1);
    chk(lastOp, 8'h0B);
    chk(lastAddr, 24'h000010);
    @(posedge ref_clk);
    #2 progReady = 1'b1;
    k = 0;
    for (int i = 0; i < 2000 && k < 12; i++)
    begin
      @(negedge ref_clk);
      if (progValid === 1'b1)
      begin
        chk(progData, 8'hB0 + k[7:0]);
        k++;
      end
    end
    chk(k, 12);
    for (int i = 0; i < 50 && initCompletePin !== 1'b1; i++) @(negedge ref_clk);
    chk(initCompletePin, 1'b1);
    chk(32'(frames - f0), 2);
    chk(errs, 0);
  endtask : t_boot

  // One byte written through the write-request port
  task automatic t_write;
    int f0;
    f0 = frames;
    @(posedge ref_clk);
    #2 pgmValid = 1'b1;
    // User data kept in its own region, clear of the boot area
    pgmAddr = 24'h000020;
    pgmData = 8'h5A;
    for (int i = 0; i < 20 && pgmReady !== 1'b1; i++) @(negedge ref_clk);
    chk(pgmReady, 1'b1);
    @(posedge ref_clk);
    #2 pgmValid = 1'b0;
    chk(pgmReady, 1'b0);
    for (int i = 0; i < 1000 && frames - f0 < 2; i++) @(negedge ref_clk);
    chk(32'(frames - f0), 2);
    chk(lastOp, 8'h02);
    chk(u_flash.mem[8'h20], 8'h5A);
    chk(errs, 0);
  endtask : t_write

  task automatic t_off;
    @(posedge ref_clk);
    #2 projectorPowerRequest = 1'b0;
    for (int i = 0; i < 10 && systemPowerEn !== 1'b0; i++) @(negedge ref_clk);
    chk(systemPowerEn, 1'b0);
    chk(initCompletePin, 1'b0);
  endtask : t_off

  // ----------------------------------------------------------------
  // Sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    rst_n = 1'b0;
    projectorPowerRequest = 1'b0;
    progReady = 1'b0;
    pgmValid = 1'b0;
    pgmAddr = 24'h000000;
    pgmData = 8'h00;
    extOn = 1'b0;
    extSck = 1'b0;
    extCs = 1'b1;
    extMosi = 1'b0;
    repeat (12) @(posedge ref_clk);
    #2 rst_n = 1'b1;
    t_programmer;
    t_boot;
    t_write;
    t_off;
    results;
  end

  // Whole run needs about 1000 cycles
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    nMismatch++;
    results;
  end
endmodule : spi_flash_boot_reader_tb

`default_nettype wire
